// *** verilog/status_consts.vh ***
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH

// ----------------------------------------------------------------------
// Widths and masks
// ----------------------------------------------------------------------
`define WORD_W          16
`define WORD_MASK       16'h7FFF
`define SET_COUNT       11
`define SEL_W           4
`define SUB_W           3
`define BYTE_MASK       16'h00FF

// ----------------------------------------------------------------------
// Status set selectors
// ----------------------------------------------------------------------
`define SET_DEVICE      4'h0
`define SET_OPER        4'h1
`define SET_OPER_CAL    4'h2
`define SET_LOW_FAIL    4'h3
`define SET_OPER_MEAS   4'h4
`define SET_OPER_SENSE  4'h5
`define SET_OPER_TRIG   4'h6
`define SET_HIGH_FAIL   4'h7
`define SET_QUES        4'h8
`define SET_QUES_CAL    4'h9
`define SET_QUES_POW    4'hA
`define SET_LAST        4'hA
`define SEL_IEEE        4'hB
`define SEL_QUEUE       4'hC

// ----------------------------------------------------------------------
// Subcommands of a status set
// ----------------------------------------------------------------------
`define SUB_EVENT       3'h0
`define SUB_COND        3'h1
`define SUB_ENABLE      3'h2
`define SUB_NTR         3'h3
`define SUB_PTR         3'h4

// ----------------------------------------------------------------------
// Subcommands of the IEEE 488.2 group and of the queue
// ----------------------------------------------------------------------
`define SUB_ESE         3'h0
`define SUB_SRE         3'h1
`define SUB_SESR        3'h2
`define SUB_STB         3'h3
`define SUB_QENABLE     3'h0
`define SUB_QPOP        3'h1

// ----------------------------------------------------------------------
// Preset and reset values
// ----------------------------------------------------------------------
`define PTR_PRESET      16'h7FFF
`define NTR_PRESET      16'h0000
`define ENABLE_PRESET   16'h0000
`define QUEUE_EN_PRESET 16'h7FFF
`define ZERO_WORD       16'h0000
`define ZERO_BYTE       8'h00
`define QUEUE_DEPTH     8
`define QUEUE_PTR_W     3

`endif

// *** verilog/status_set.v ***
`include "status_consts.vh"

module status_set (
  // Clock and reset
  input  wire                 sys_clk,
  input  wire                 rst,
  // Global actions
  input  wire                 cls_cmd,
  input  wire                 preset_cmd,
  // Live condition bits
  input  wire [`WORD_W-1:0]   cond_in,
  // Host access
  input  wire                 wr_enable,
  input  wire                 wr_ntr,
  input  wire                 wr_ptr,
  input  wire                 rd_event,
  input  wire [`WORD_W-1:0]   wr_data,
  // Register contents
  output wire [`WORD_W-1:0]   cond_bits,
  output wire [`WORD_W-1:0]   latched_event_bits,
  output wire [`WORD_W-1:0]   enable_bits,
  output wire [`WORD_W-1:0]   ntr_bits,
  output wire [`WORD_W-1:0]   ptr_bits,
  output wire                 summary
);

  reg  [`WORD_W-1:0] cond_q;
  reg  [`WORD_W-1:0] event_q;
  reg  [`WORD_W-1:0] event_d;
  reg  [`WORD_W-1:0] enable_q;
  reg  [`WORD_W-1:0] ntr_q;
  reg  [`WORD_W-1:0] ptr_q;
  wire [`WORD_W-1:0] cond_next;
  wire [`WORD_W-1:0] rise;
  wire [`WORD_W-1:0] fall;
  wire [`WORD_W-1:0] hit;

  // ----------------------------------------------------------------------
  // Transition detection
  // ----------------------------------------------------------------------
  // top bit held zero
  assign cond_next = cond_in & `WORD_MASK;
  assign rise      = cond_next & ~cond_q;
  assign fall      = ~cond_next & cond_q;
  assign hit       = (rise & ptr_q) | (fall & ntr_q);

  // An edge in the cycle of a clearing read or clear-status is kept.
  always @* begin
    event_d = event_q;
    if (rd_event) begin
      event_d = `ZERO_WORD;
    end
    if (cls_cmd) begin
      event_d = `ZERO_WORD;
    end
    event_d = (event_d | hit) & `WORD_MASK;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      cond_q   <= `ZERO_WORD;
      event_q  <= `ZERO_WORD;
      enable_q <= `ENABLE_PRESET;
      ntr_q    <= `NTR_PRESET;
      ptr_q    <= `PTR_PRESET;
    end else begin
      cond_q  <= cond_next;
      event_q <= event_d;
      if (preset_cmd) begin
        ntr_q <= `NTR_PRESET;
        ptr_q <= `PTR_PRESET;
      end else begin
        if (wr_ntr) begin
          ntr_q <= wr_data & `WORD_MASK;
        end
        if (wr_ptr) begin
          ptr_q <= wr_data & `WORD_MASK;
        end
      end
      if (preset_cmd) begin
        enable_q <= `ENABLE_PRESET;
      end else if (wr_enable) begin
        enable_q <= wr_data & `WORD_MASK;
      end
    end
  end

  assign cond_bits          = cond_q;
  assign latched_event_bits = event_q;
  assign enable_bits        = enable_q;
  assign ntr_bits           = ntr_q;
  assign ptr_bits           = ptr_q;
  assign summary            = |(event_q & enable_q);

endmodule

// *** verilog/status_reporting.v ***
`include "status_consts.vh"

module status_reporting #(
  parameter QDEPTH = `QUEUE_DEPTH,
  parameter QPW    = `QUEUE_PTR_W
) (
  // Clock and reset
  input  wire                            sys_clk,
  input  wire                            rst,
  // Global actions
  input  wire                            cls_cmd,
  input  wire                            dev_reset_cmd,
  input  wire                            preset_cmd,
  // Condition bits of the eleven sets, set 0 in the low word
  input  wire [`SET_COUNT*`WORD_W-1:0]   cond_in,
  // IEEE 488.2 event sources
  input  wire [7:0]                      sesr_set,
  input  wire [7:0]                      stb_set,
  // Error/event queue source
  input  wire                            err_push,
  input  wire [3:0]                      err_class,
  input  wire [`WORD_W-1:0]              err_code,
  // Host command port
  input  wire                            cmd_valid,
  input  wire                            cmd_write,
  input  wire [`SEL_W-1:0]               cmd_sel,
  input  wire [`SUB_W-1:0]               cmd_sub,
  input  wire [`WORD_W-1:0]              cmd_data,
  // Host answer port
  output reg                             resp_valid,
  output reg                             resp_error,
  output reg  [`WORD_W-1:0]              resp_data,
  // Set summaries
  output reg  [`SET_COUNT-1:0]           set_summary
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function [`WORD_W-1:0] pick_word;
    input [`SET_COUNT*`WORD_W-1:0] bus;
    input [`SEL_W-1:0]             sel;
    integer                        k;
    begin
      pick_word = `ZERO_WORD;
      for (k = 0; k < `SET_COUNT; k = k + 1) begin
        if (sel == k[`SEL_W-1:0]) begin
          pick_word = bus[k*`WORD_W +: `WORD_W];
        end
      end
    end
  endfunction

  function [QPW-1:0] ptr_inc;
    input [QPW-1:0] p;
    begin
      ptr_inc = (p == QDEPTH - 1) ? {QPW{1'b0}} : p + 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire                   sel_is_set;
  wire                   sel_ieee;
  wire                   sel_queue;
  wire                   sub_cond;
  wire                   sub_enable;
  wire                   sub_ntr;
  wire                   sub_ptr;
  wire                   sub_event;
  wire [`SET_COUNT-1:0]  hit_set;
  wire [`SET_COUNT-1:0]  wr_enable;
  wire [`SET_COUNT-1:0]  wr_ntr;
  wire [`SET_COUNT-1:0]  wr_ptr;
  wire [`SET_COUNT-1:0]  rd_event;

  assign sel_is_set = cmd_sel <= `SET_LAST;
  assign sel_ieee   = cmd_sel == `SEL_IEEE;
  assign sel_queue  = cmd_sel == `SEL_QUEUE;
  assign sub_cond   = cmd_sub == `SUB_COND;
  assign sub_enable = cmd_sub == `SUB_ENABLE;
  assign sub_ntr    = cmd_sub == `SUB_NTR;
  assign sub_ptr    = cmd_sub == `SUB_PTR;
  assign sub_event  = ~(sub_cond | sub_enable | sub_ntr | sub_ptr);

  // ----------------------------------------------------------------------
  // Eleven status sets
  // ----------------------------------------------------------------------
  wire [`SET_COUNT*`WORD_W-1:0] cond_bus;
  wire [`SET_COUNT*`WORD_W-1:0] event_bus;
  wire [`SET_COUNT*`WORD_W-1:0] enable_bus;
  wire [`SET_COUNT*`WORD_W-1:0] ntr_bus;
  wire [`SET_COUNT*`WORD_W-1:0] ptr_bus;
  wire [`SET_COUNT-1:0]         summary_w;

  genvar g;
  generate
    for (g = 0; g < `SET_COUNT; g = g + 1) begin : sets
      assign hit_set[g]   = cmd_valid & sel_is_set & (cmd_sel == g);
      assign wr_enable[g] = hit_set[g] & cmd_write & sub_enable;
      assign wr_ntr[g]    = hit_set[g] & cmd_write & sub_ntr;
      assign wr_ptr[g]    = hit_set[g] & cmd_write & sub_ptr;
      assign rd_event[g]  = hit_set[g] & ~cmd_write & sub_event;

      status_set u_status_set (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .cls_cmd            (cls_cmd),
        .preset_cmd         (preset_cmd),
        .cond_in            (cond_in[g*`WORD_W +: `WORD_W]),
        .wr_enable          (wr_enable[g]),
        .wr_ntr             (wr_ntr[g]),
        .wr_ptr             (wr_ptr[g]),
        .rd_event           (rd_event[g]),
        .wr_data            (cmd_data),
        .cond_bits          (cond_bus[g*`WORD_W +: `WORD_W]),
        .latched_event_bits (event_bus[g*`WORD_W +: `WORD_W]),
        .enable_bits        (enable_bus[g*`WORD_W +: `WORD_W]),
        .ntr_bits           (ntr_bus[g*`WORD_W +: `WORD_W]),
        .ptr_bits           (ptr_bus[g*`WORD_W +: `WORD_W]),
        .summary            (summary_w[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // IEEE 488.2 registers
  // ----------------------------------------------------------------------
  reg  [7:0] ese_q;
  reg  [7:0] sre_q;
  reg  [7:0] sesr_q;
  reg  [7:0] stb_q;
  wire       ieee_acc;
  wire       sesr_rd;

  assign ieee_acc = cmd_valid & sel_ieee;
  assign sesr_rd  = ieee_acc & ~cmd_write & (cmd_sub == `SUB_SESR);

  always @(posedge sys_clk) begin
    if (rst) begin
      ese_q  <= `ZERO_BYTE;
      sre_q  <= `ZERO_BYTE;
      sesr_q <= `ZERO_BYTE;
      stb_q  <= `ZERO_BYTE;
    end else begin
      if (ieee_acc & cmd_write & (cmd_sub == `SUB_ESE)) begin
        ese_q <= cmd_data[7:0];
      end
      if (ieee_acc & cmd_write & (cmd_sub == `SUB_SRE)) begin
        sre_q <= cmd_data[7:0];
      end
      sesr_q <= ((cls_cmd | sesr_rd) ? `ZERO_BYTE : sesr_q) | sesr_set;
      stb_q  <= (cls_cmd ? `ZERO_BYTE : stb_q) | stb_set;
    end
  end

  // ----------------------------------------------------------------------
  // Error/event queue
  // ----------------------------------------------------------------------
  reg  [`WORD_W-1:0] qmem [0:QDEPTH-1];
  reg  [`WORD_W-1:0] qen_q;
  reg  [QPW-1:0]     wp_q;
  reg  [QPW-1:0]     rp_q;
  reg  [QPW:0]       cnt_q;
  wire               q_empty;
  wire               q_full;
  wire               q_push;
  wire               q_pop;

  assign q_empty = cnt_q == {(QPW+1){1'b0}};
  assign q_full  = cnt_q == QDEPTH;
  assign q_push  = err_push & qen_q[err_class] & ~q_full & ~cls_cmd;
  assign q_pop   = cmd_valid & sel_queue & ~cmd_write & (cmd_sub == `SUB_QPOP) & ~q_empty
                   & ~cls_cmd;

  always @(posedge sys_clk) begin
    if (q_push) begin
      qmem[wp_q] <= err_code;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      qen_q <= `QUEUE_EN_PRESET;
      wp_q  <= {QPW{1'b0}};
      rp_q  <= {QPW{1'b0}};
      cnt_q <= {(QPW+1){1'b0}};
    end else begin
      if (preset_cmd) begin
        qen_q <= `QUEUE_EN_PRESET;
      end else if (cmd_valid & sel_queue & cmd_write & (cmd_sub == `SUB_QENABLE)) begin
        qen_q <= cmd_data & `WORD_MASK;
      end
      if (cls_cmd) begin
        wp_q  <= {QPW{1'b0}};
        rp_q  <= {QPW{1'b0}};
        cnt_q <= {(QPW+1){1'b0}};
      end else begin
        if (q_push) begin
          wp_q <= ptr_inc(wp_q);
        end
        if (q_pop) begin
          rp_q <= ptr_inc(rp_q);
        end
        if (q_push & ~q_pop) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (q_pop & ~q_push) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answer path
  // ----------------------------------------------------------------------
  reg  [`WORD_W-1:0] data_d;
  reg                err_d;
  reg                valid_d;

  always @* begin
    data_d  = `ZERO_WORD;
    err_d   = 1'b0;
    valid_d = cmd_valid & ~cmd_write;
    if (sel_is_set) begin
      if (sub_cond) begin
        err_d  = cmd_write;
        data_d = pick_word(cond_bus, cmd_sel);
      end else if (sub_enable) begin
        data_d = pick_word(enable_bus, cmd_sel);
      end else if (sub_ntr) begin
        data_d = pick_word(ntr_bus, cmd_sel);
      end else if (sub_ptr) begin
        data_d = pick_word(ptr_bus, cmd_sel);
      end else begin
        err_d  = cmd_write;
        data_d = pick_word(event_bus, cmd_sel);
      end
    end else if (sel_ieee) begin
      case (cmd_sub)
        `SUB_ESE: data_d = {`ZERO_BYTE, ese_q};
        `SUB_SRE: data_d = {`ZERO_BYTE, sre_q};
        `SUB_SESR: begin
          err_d  = cmd_write;
          data_d = {`ZERO_BYTE, sesr_q};
        end
        `SUB_STB: begin
          err_d  = cmd_write;
          data_d = {`ZERO_BYTE, stb_q};
        end
        default: err_d = 1'b1;
      endcase
    end else if (sel_queue) begin
      case (cmd_sub)
        `SUB_QENABLE: data_d = qen_q;
        `SUB_QPOP: begin
          err_d  = cmd_write;
          data_d = q_empty ? `ZERO_WORD : qmem[rp_q];
        end
        default: err_d = 1'b1;
      endcase
    end else begin
      err_d = 1'b1;
    end
    // Writes to query-only targets and bad selectors still answer.
    if (cmd_valid & err_d) begin
      valid_d = 1'b1;
      data_d  = `ZERO_WORD;
    end
    if (~cmd_valid) begin
      err_d  = 1'b0;
      data_d = `ZERO_WORD;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      resp_valid  <= 1'b0;
      resp_error  <= 1'b0;
      resp_data   <= `ZERO_WORD;
      set_summary <= {`SET_COUNT{1'b0}};
    end else begin
      resp_valid  <= valid_d;
      resp_error  <= err_d;
      resp_data   <= data_d & ((sel_ieee) ? `BYTE_MASK : `WORD_MASK);
      set_summary <= summary_w;
    end
  end

endmodule

// *** bench/status_checks_properties.sv ***
`include "status_consts.vh"

module status_checks #(
  parameter QDEPTH = `QUEUE_DEPTH,
  parameter QPW    = `QUEUE_PTR_W
) (
  // Clock and reset
  input wire                          sys_clk,
  input wire                          rst,
  // Global actions and conditions
  input wire                          cls_cmd,
  input wire                          preset_cmd,
  input wire [`SET_COUNT*`WORD_W-1:0] cond_in,
  // Host command and answer
  input wire                          cmd_valid,
  input wire                          cmd_write,
  input wire [`SEL_W-1:0]             cmd_sel,
  input wire [`SUB_W-1:0]             cmd_sub,
  input wire                          resp_valid,
  input wire                          resp_error,
  input wire [`WORD_W-1:0]            resp_data,
  input wire [`SET_COUNT-1:0]         set_summary
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wire               set_ok   = cmd_sel <= `SET_LAST;
  wire               query    = cmd_valid && !cmd_write;
  wire               ev_query = query && set_ok && (cmd_sub == 3'h0 || cmd_sub > 3'h4);
  wire [`WORD_W-1:0] sel_cond = cond_in[16*cmd_sel +: 16];

  top_bit_zero_a: assert property (!resp_data[15])
    else $error("answer bit 15 is set");
  query_answer_a: assert property (query |=> resp_valid)
    else $error("query without answer");
  good_write_a: assert property (cmd_valid && cmd_write && set_ok
    && cmd_sub inside {[3'h2:3'h4]} |=> !resp_valid) else $error("accepted write answered");
  bad_write_a: assert property (cmd_valid && cmd_write && set_ok && cmd_sub < 3'h2
    |=> resp_valid && resp_error && resp_data == 16'h0000) else $error("bad write not refused");
  bad_select_a: assert property (cmd_valid && cmd_sel > `SEL_QUEUE
    |=> resp_error && resp_data == 16'h0000) else $error("bad selector not refused");
  idle_quiet_a: assert property (!cmd_valid |=> !resp_valid)
    else $error("answer without command");
  cond_read_a: assert property ($stable(cond_in) ##1 ($stable(cond_in) && query && set_ok
    && cmd_sub == 3'h1) |=> resp_data == ($past(sel_cond) & `WORD_MASK))
    else $error("condition answer wrong");
  event_clear_a: assert property ($stable(cond_in) && ev_query
    ##1 $stable(cond_in) && !cmd_valid
    ##1 $stable(cond_in) && ev_query && cmd_sel == $past(cmd_sel, 2) |=> resp_data == 16'h0000)
    else $error("event not cleared by read");
  cls_clear_a: assert property (cls_cmd && $stable(cond_in) ##1 $stable(cond_in)
    |=> set_summary == 11'h000) else $error("summary kept after clear");
  preset_clear_a: assert property (preset_cmd |-> ##2 set_summary == 11'h000)
    else $error("summary kept after preset");

  cover property (ev_query);
  cover property (query && cmd_sub == 3'h1);
  cover property (cls_cmd);
  cover property (preset_cmd);
endmodule

bind status_reporting status_checks #(.QDEPTH(QDEPTH), .QPW(QPW)) u_status_checks (
  .sys_clk(sys_clk), .rst(rst), .cls_cmd(cls_cmd), .preset_cmd(preset_cmd),
  .cond_in(cond_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
  .cmd_sub(cmd_sub), .resp_valid(resp_valid), .resp_error(resp_error),
  .resp_data(resp_data), .set_summary(set_summary));

// *** bench/host_model.sv ***
module host_model (
  // Clock
  input  wire logic        sys_clk,
  // Command port
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [3:0]       cmd_sel,
  output logic [2:0]       cmd_sub,
  output logic [15:0]      cmd_data,
  // Answer port
  input  wire logic        resp_valid,
  input  wire logic        resp_error,
  input  wire logic [15:0] resp_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        rv;
  logic        re;
  logic [15:0] rd;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel   = 4'h0;
    cmd_sub   = 3'h0;
    cmd_data  = 16'h0000;
  end

  task issue(input logic w, input logic [3:0] sel, input logic [2:0] sub, input logic [15:0] d);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel   = sel;
    cmd_sub   = sub;
    cmd_data  = d;
    @(negedge sys_clk);
    rv = resp_valid;
    re = resp_error;
    rd = resp_data;
    // Released lines show the inverse so stale values never look valid.
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_sel   = ~sel;
    cmd_sub   = ~sub;
    cmd_data  = ~d;
  endtask
endmodule

// *** bench/scpi_status_register_sets_tb.sv ***
`include "status_consts.vh"

module scpi_status_register_sets_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          sys_clk;
  logic                          rst;
  logic                          cls_cmd;
  logic                          dev_reset_cmd;
  logic                          preset_cmd;
  logic [`SET_COUNT*`WORD_W-1:0] cond_in;
  logic [7:0]                    sesr_set;
  logic [7:0]                    stb_set;
  logic                          err_push;
  logic [3:0]                    err_class;
  logic [`WORD_W-1:0]            err_code;
  wire                           cmd_valid;
  wire                           cmd_write;
  wire  [`SEL_W-1:0]             cmd_sel;
  wire  [`SUB_W-1:0]             cmd_sub;
  wire  [`WORD_W-1:0]            cmd_data;
  wire                           resp_valid;
  wire                           resp_error;
  wire  [`WORD_W-1:0]            resp_data;
  wire  [`SET_COUNT-1:0]         set_summary;
  int                            mismatches;
  int                            samples_checked;

  status_reporting u_status_reporting (
    .sys_clk(sys_clk), .rst(rst), .cls_cmd(cls_cmd), .dev_reset_cmd(dev_reset_cmd),
    .preset_cmd(preset_cmd), .cond_in(cond_in), .sesr_set(sesr_set), .stb_set(stb_set),
    .err_push(err_push), .err_class(err_class), .err_code(err_code),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_sub(cmd_sub),
    .cmd_data(cmd_data), .resp_valid(resp_valid), .resp_error(resp_error),
    .resp_data(resp_data), .set_summary(set_summary));

  host_model u_host_model (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
    .cmd_sub(cmd_sub), .cmd_data(cmd_data), .resp_valid(resp_valid),
    .resp_error(resp_error), .resp_data(resp_data));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task query(input logic [3:0] sel, input logic [2:0] sub, input logic [15:0] exp);
    u_host_model.issue(1'b0, sel, sub, 16'h0000);
    chk({u_host_model.rv, u_host_model.re, u_host_model.rd}, {2'b10, exp});
  endtask

  task wr(input logic [3:0] sel, input logic [2:0] sub, input logic [15:0] d);
    u_host_model.issue(1'b1, sel, sub, d);
    chk(18'(u_host_model.rv), 18'h00000);
  endtask

  task bad(input logic w, input logic [3:0] sel, input logic [2:0] sub);
    u_host_model.issue(w, sel, sub, 16'hFFFF);
    chk({u_host_model.rv, u_host_model.re, u_host_model.rd}, {2'b11, 16'h0000});
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask

  // Waits long enough for a latched event to reach the summary outputs.
  task set_cond(input int k, input logic [15:0] v);
    @(negedge sys_clk);
    cond_in[16*k +: 16] = v;
    repeat (3) @(negedge sys_clk);
  endtask

  task sources(input logic [7:0] se, input logic [7:0] sb, input logic [15:0] code);
    @(negedge sys_clk);
    sesr_set = se;
    stb_set  = sb;
    err_push = 1'b1;
    err_code = code;
    @(negedge sys_clk);
    sesr_set = 8'h00;
    stb_set  = 8'h00;
    err_push = 1'b0;
    err_code = ~code;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task reset_values;
    for (int k = 0; k <= 10; k++) begin
      query(4'(k), 3'h2, 16'h0000);
      query(4'(k), 3'h3, 16'h0000);
      query(4'(k), 3'h4, 16'h7FFF);
    end
    query(4'hB, 3'h0, 16'h0000);
    query(4'hB, 3'h1, 16'h0000);
    query(4'hC, 3'h0, 16'h7FFF);
  endtask

  task write_masks;
    for (int k = 0; k <= 10; k++) begin
      wr(4'(k), 3'h2, 16'hFFFF);
      wr(4'(k), 3'h3, 16'hAAAA);
      wr(4'(k), 3'h4, 16'hD555);
      query(4'(k), 3'h2, 16'h7FFF);
      query(4'(k), 3'h3, 16'h2AAA);
      query(4'(k), 3'h4, 16'h5555);
    end
  endtask

  task edge_events;
    set_cond(3, 16'h8003);
    chk(18'(set_summary), 18'h00008);
    query(4'h3, 3'h1, 16'h0003);
    query(4'h3, 3'h1, 16'h0003);
    set_cond(3, 16'h0000);
    query(4'h3, 3'h0, 16'h0003);
    query(4'h3, 3'h7, 16'h0000);
    chk(18'(set_summary), 18'h00000);
  endtask

  task global_actions;
    set_cond(0, 16'h0001);
    sources(8'h01, 8'h04, 16'h1234);
    wr(4'hB, 3'h0, 16'h000F);
    wr(4'hB, 3'h1, 16'h00F0);
    pulse(dev_reset_cmd);
    chk(18'(set_summary), 18'h00001);
    query(4'hB, 3'h0, 16'h000F);
    query(4'h0, 3'h4, 16'h5555);
    pulse(cls_cmd);
    query(4'h0, 3'h0, 16'h0000);
    query(4'hB, 3'h2, 16'h0000);
    query(4'hB, 3'h3, 16'h0000);
    query(4'hC, 3'h1, 16'h0000);
    query(4'hB, 3'h1, 16'h00F0);
    query(4'h0, 3'h2, 16'h7FFF);
    query(4'h0, 3'h3, 16'h2AAA);
    wr(4'hC, 3'h0, 16'h8004);
    query(4'hC, 3'h0, 16'h0004);
    err_class = 4'h3;
    sources(8'h00, 8'h00, 16'h0DEF);
    err_class = 4'h2;
    set_cond(0, 16'h0005);
    sources(8'h02, 8'h00, 16'h0ABC);
    pulse(preset_cmd);
    query(4'h0, 3'h4, 16'h7FFF);
    query(4'h0, 3'h3, 16'h0000);
    query(4'h0, 3'h2, 16'h0000);
    query(4'hC, 3'h0, 16'h7FFF);
    query(4'hB, 3'h0, 16'h000F);
    query(4'hB, 3'h2, 16'h0002);
    query(4'h0, 3'h0, 16'h0004);
    query(4'hC, 3'h1, 16'h0ABC);
    query(4'hC, 3'h1, 16'h0000);
  endtask

  task refusals;
    bad(1'b1, 4'h4, 3'h1);
    bad(1'b0, 4'hD, 3'h0);
    bad(1'b1, 4'hB, 3'h2);
    bad(1'b0, 4'hB, 3'h5);
    bad(1'b0, 4'hC, 3'h2);
    query(4'h4, 3'h1, 16'h0000);
  endtask

  task complete_run;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    mismatches      = 0;
    samples_checked = 0;
    rst             = 1'b1;
    cls_cmd         = 1'b0;
    dev_reset_cmd   = 1'b0;
    preset_cmd      = 1'b0;
    cond_in         = {`SET_COUNT{16'h0000}};
    sesr_set        = 8'h00;
    stb_set         = 8'h00;
    err_push        = 1'b0;
    err_class       = 4'h2;
    err_code        = 16'h0000;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    reset_values();
    write_masks();
    edge_events();
    global_actions();
    refusals();
    complete_run();
  end

  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
endmodule
